// [core/mvd_core.sv]
// Memory map decode: RAM, stack engine, vector table and system registers.
// Assumes one CPU master on a strobe bus with read data one cycle later,
// and interrupt sources that hold their request level until served.
module mvd_core #(
  parameter logic [7:0]             RESET_VEC_LO = 8'h00,      // Arbitrary default.
  parameter logic [7:0]             PROTECT_INIT = 8'hFF,      // Nonvolatile protect image.
  parameter logic [mvd_pkg::WDOG_W-1:0] WDOG_LIMIT = 20'hFFFFF // Watchdog last count; span is limit plus one cycles.
) (
  input  wire logic        i_sys_clk,      // System clock, 50 MHz.
  input  wire logic        i_reset_n,      // Asynchronous reset, active low.
  input  wire logic [15:0] i_addr,         // Bus address.
  input  wire logic [7:0]  i_wdata,        // Bus write data.
  input  wire logic        i_wr,           // Write strobe.
  input  wire logic        i_rd,           // Read strobe.
  output logic      [7:0]  o_rdata,        // Read data, cycle after strobe.
  input  wire logic        i_stack_irq,    // Start interrupt entry frame.
  input  wire logic        i_stack_call,   // Start call frame.
  input  wire logic        i_stack_push,   // Push one byte.
  input  wire logic        i_stack_pull,   // Pull one byte.
  input  wire logic        i_sp_load,      // Load stack pointer.
  input  wire logic [15:0] i_sp_value,     // Value for load.
  input  wire logic [7:0]  i_push_data,    // Byte for single push.
  input  wire logic [15:0] i_pc,           // Return address.
  input  wire logic [7:0]  i_x,            // Low index register.
  input  wire logic [7:0]  i_acc,          // Accumulator.
  input  wire logic [7:0]  i_ccr,          // Condition codes.
  output logic      [15:0] o_sp,           // Stack pointer.
  output logic             o_stack_busy,   // Frame push in progress.
  output logic      [7:0]  o_pull_data,    // Byte pulled last cycle.
  input  wire logic [19:0] i_int_req,      // Source requests, bit 0 highest address.
  input  wire logic        i_swi,          // Software interrupt request.
  input  wire logic        i_vec_fetch,    // Vector fetch strobe.
  output logic      [15:0] o_vec_addr,     // Address of fetched vector.
  output logic      [15:0] o_vector,       // Fetched vector value.
  output logic             o_vec_valid,    // Vector outputs valid.
  input  wire logic        i_break_match,  // Break comparator hit.
  output logic             o_break_enable, // Break enable bit.
  output logic      [7:0]  o_break_low,    // Break address low byte.
  input  wire logic        i_low_voltage,  // Low-voltage pin, asynchronous.
  output logic      [7:0]  o_protect,      // Block protect byte.
  output logic             o_wdog_timeout, // Watchdog expired, one cycle.
  output logic             o_irq           // Level interrupt.
);

  typedef enum logic [0:0] {
    MVD_IDLE = 1'b0,
    MVD_PUSH = 1'b1
  } mvd_stk_e;

  typedef struct packed {
    logic [mvd_pkg::RAM_BYTES-1:0][7:0] ram;
    logic [mvd_pkg::VEC_BYTES-1:0][7:0] vec;
    logic [15:0]               sp;
    mvd_stk_e                  stk;
    logic [2:0]                cnt;
    logic [2:0]                len;
    logic [4:0][7:0]           frame;
    logic [7:0]                rdata;
    logic [7:0]                pull_data;
    logic [15:0]               vec_addr;
    logic [15:0]               vector;
    logic                      vec_valid;
    logic [7:0]                brk_lo;
    logic                      brk_en;
    logic                      brk_act;
    logic [2:0]                lv_sync;
    logic                      lv_level;
    logic [7:0]                protect;
    logic [mvd_pkg::WDOG_W-1:0] wdog_cnt;
    logic                      wdog_to;
    logic [mvd_pkg::NUM_EV-1:0] status;
    logic [mvd_pkg::NUM_EV-1:0] mask;
  } mvd_state_s;

  mvd_state_s s_ff;
  mvd_state_s nxt_s;

  // Address decode shared by bus, stack and fetch paths.
  function automatic logic is_ram(input logic [15:0] a);
    return (a >= mvd_pkg::RAM_FIRST) && (a <= mvd_pkg::RAM_LAST);
  endfunction

  function automatic logic [mvd_pkg::RAM_IDX_W-1:0] ram_idx(input logic [15:0] a);
    logic [15:0] d;
    d = a - mvd_pkg::RAM_FIRST;
    return d[mvd_pkg::RAM_IDX_W-1:0];
  endfunction

  function automatic logic [mvd_pkg::VEC_IDX_W-1:0] vec_idx(input logic [15:0] a);
    logic [15:0] d;
    d = a - mvd_pkg::VEC_FIRST;
    return d[mvd_pkg::VEC_IDX_W-1:0];
  endfunction

  function automatic logic is_vec(input logic [15:0] a);
    return a >= mvd_pkg::VEC_FIRST;
  endfunction

  // The last byte is the watchdog location, so its read is the fixed low byte.
  function automatic logic [7:0] vec_byte(input logic [mvd_pkg::VEC_BYTES-1:0][7:0] v,
                                          input logic [15:0] a);
    if (a == mvd_pkg::WDOG_ADDR) begin
      return RESET_VEC_LO;
    end
    return v[vec_idx(a)];
  endfunction

  // Vector for source i: the first source sits just below software interrupt.
  function automatic logic [15:0] src_vec(input int i);
    return 16'(mvd_pkg::VEC_SWI - 16'(mvd_pkg::VEC_STRIDE * 16'(i + 1)));
  endfunction

  // Next-state logic for the whole block.
  always_comb begin
    logic [15:0] sel;
    logic [15:0] spn;
    logic        lv_rise;
    logic [2:0]  ev;
    sel     = mvd_pkg::VEC_RESET;
    spn     = s_ff.sp + mvd_pkg::SP_STEP;
    lv_rise = 1'b0;
    ev      = '0;
    nxt_s   = s_ff;

    // Low-voltage pin: a change counts once the last two stages agree.
    nxt_s.lv_sync = {s_ff.lv_sync[1:0], i_low_voltage};
    if (s_ff.lv_sync[1] == s_ff.lv_sync[2]) begin
      nxt_s.lv_level = s_ff.lv_sync[2];
    end
    lv_rise = nxt_s.lv_level & ~s_ff.lv_level;

    // Watchdog free-runs; a timeout restarts it and raises an event.
    nxt_s.wdog_to  = 1'b0;
    nxt_s.wdog_cnt = s_ff.wdog_cnt + 1'b1;
    if (s_ff.wdog_cnt == WDOG_LIMIT) begin
      nxt_s.wdog_cnt = '0;
      nxt_s.wdog_to  = 1'b1;
    end

    // Read data stands for one cycle only, zero otherwise and for holes.
    nxt_s.rdata = mvd_pkg::BYTE_ZERO;
    if (i_rd) begin
      if (is_ram(i_addr)) begin
        nxt_s.rdata = s_ff.ram[ram_idx(i_addr)];
      end else if (is_vec(i_addr)) begin
        nxt_s.rdata = vec_byte(s_ff.vec, i_addr);
      end else begin
        unique case (i_addr)
          mvd_pkg::BRK_LO_ADDR:   nxt_s.rdata = s_ff.brk_lo;
          mvd_pkg::BRK_SC_ADDR:   nxt_s.rdata = {s_ff.brk_en, s_ff.brk_act, 6'h00};
          mvd_pkg::LVS_ADDR:      nxt_s.rdata = {s_ff.lv_level, 7'h00};
          mvd_pkg::IRQ_STAT_ADDR: nxt_s.rdata = {5'h00, s_ff.status};
          mvd_pkg::IRQ_MASK_ADDR: nxt_s.rdata = {5'h00, s_ff.mask};
          mvd_pkg::PROTECT_ADDR:  nxt_s.rdata = s_ff.protect;
          default:                nxt_s.rdata = mvd_pkg::BYTE_ZERO;
        endcase
      end
    end

    // Bus writes; the low-voltage byte ignores writes entirely.
    if (i_wr) begin
      if (is_ram(i_addr)) begin
        nxt_s.ram[ram_idx(i_addr)] = i_wdata;
      end else if (i_addr == mvd_pkg::WDOG_ADDR) begin
        nxt_s.wdog_cnt = '0;
        nxt_s.wdog_to  = 1'b0;
      end else if (is_vec(i_addr)) begin
        nxt_s.vec[vec_idx(i_addr)] = i_wdata;
      end else begin
        unique case (i_addr)
          mvd_pkg::BRK_LO_ADDR: nxt_s.brk_lo = i_wdata;
          mvd_pkg::BRK_SC_ADDR: begin
            nxt_s.brk_en = i_wdata[mvd_pkg::BRK_EN_BIT];
            if (!i_wdata[mvd_pkg::BRK_ACT_BIT]) begin
              nxt_s.brk_act = 1'b0;
            end
          end
          mvd_pkg::IRQ_STAT_ADDR: nxt_s.status = s_ff.status & ~i_wdata[mvd_pkg::NUM_EV-1:0];
          mvd_pkg::IRQ_MASK_ADDR: nxt_s.mask = i_wdata[mvd_pkg::NUM_EV-1:0];
          mvd_pkg::PROTECT_ADDR:  nxt_s.protect = i_wdata;
          default: ;
        endcase
      end
    end

    // Hardware sets come after software clears so a coincident event wins.
    if (s_ff.brk_en && i_break_match) begin
      nxt_s.brk_act = 1'b1;
    end
    ev[mvd_pkg::EV_BREAK] = s_ff.brk_en & i_break_match;
    ev[mvd_pkg::EV_LV]    = lv_rise;
    ev[mvd_pkg::EV_WDOG]  = nxt_s.wdog_to;
    nxt_s.status = nxt_s.status | ev;

    // Stack engine; it writes RAM after the bus so a stack byte wins a clash.
    // Bytes aimed outside RAM are dropped, software must avoid that.
    unique case (s_ff.stk)
      MVD_IDLE: begin
        if (i_stack_irq) begin
          nxt_s.frame = {i_ccr, i_acc, i_x, i_pc[15:8], i_pc[7:0]};
          nxt_s.len   = mvd_pkg::IRQ_FRAME;
          nxt_s.cnt   = '0;
          nxt_s.stk   = MVD_PUSH;
        end else if (i_stack_call) begin
          nxt_s.frame = {24'h000000, i_pc[15:8], i_pc[7:0]};
          nxt_s.len   = mvd_pkg::CALL_FRAME;
          nxt_s.cnt   = '0;
          nxt_s.stk   = MVD_PUSH;
        end else if (i_stack_push) begin
          if (is_ram(s_ff.sp)) begin
            nxt_s.ram[ram_idx(s_ff.sp)] = i_push_data;
          end
          nxt_s.sp = s_ff.sp - mvd_pkg::SP_STEP;
        end else if (i_stack_pull) begin
          nxt_s.sp = spn;
          nxt_s.pull_data = is_ram(spn) ? s_ff.ram[ram_idx(spn)] : mvd_pkg::BYTE_ZERO;
        end else if (i_sp_load) begin
          nxt_s.sp = i_sp_value;
        end
      end
      MVD_PUSH: begin
        if (is_ram(s_ff.sp)) begin
          nxt_s.ram[ram_idx(s_ff.sp)] = s_ff.frame[s_ff.cnt];
        end
        nxt_s.sp  = s_ff.sp - mvd_pkg::SP_STEP;
        nxt_s.cnt = s_ff.cnt + mvd_pkg::FRAME_STEP;
        if (s_ff.cnt == s_ff.len - mvd_pkg::FRAME_STEP) begin
          nxt_s.stk = MVD_IDLE;
        end
      end
    endcase

    // Vector fetch: higher address beats lower, reset when nothing waits.
    nxt_s.vec_valid = i_vec_fetch;
    if (i_vec_fetch) begin
      for (int i = mvd_pkg::NUM_IF - 1; i >= 0; i--) begin
        if (i_int_req[i]) begin
          sel = src_vec(i);
        end
      end
      if (i_swi) begin
        sel = mvd_pkg::VEC_SWI;
      end
      nxt_s.vec_addr = sel;
      nxt_s.vector   = {vec_byte(s_ff.vec, sel), vec_byte(s_ff.vec, sel + mvd_pkg::SP_STEP)};
    end
  end

  // State register; protect byte reloads its nonvolatile image at reset.
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      s_ff         <= '0;
      s_ff.sp      <= mvd_pkg::SP_RESET;
      s_ff.protect <= PROTECT_INIT;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // Outputs straight from the state register.
  assign o_rdata        = s_ff.rdata;
  assign o_sp           = s_ff.sp;
  assign o_stack_busy   = (s_ff.stk == MVD_PUSH);
  assign o_pull_data    = s_ff.pull_data;
  assign o_vec_addr     = s_ff.vec_addr;
  assign o_vector       = s_ff.vector;
  assign o_vec_valid    = s_ff.vec_valid;
  assign o_break_enable = s_ff.brk_en;
  assign o_break_low    = s_ff.brk_lo;
  assign o_protect      = s_ff.protect;
  assign o_wdog_timeout = s_ff.wdog_to;
  assign o_irq          = |(s_ff.status & s_ff.mask);

  // Checks on stack, decode and register behaviour.
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_reset_n);

  wire idle_go = (s_ff.stk == MVD_IDLE);

  a_irq_frame: assert property (idle_go && i_stack_irq |-> ##6 o_sp == $past(o_sp, 6) - 16'h0005)
    else $error("interrupt frame did not move stack by five");
  a_call_frame: assert property (idle_go && i_stack_call |=> o_stack_busy [*2] ##1 !o_stack_busy)
    else $error("call frame length wrong");
  a_push_dec: assert property (idle_go && !i_stack_irq && !i_stack_call && i_stack_push
                               |=> o_sp == $past(o_sp) - 16'h0001)
    else $error("push did not decrement stack pointer");
  a_pull_inc: assert property (idle_go && !i_stack_irq && !i_stack_call && !i_stack_push && i_stack_pull
                               |=> o_sp == $past(o_sp) + 16'h0001)
    else $error("pull did not increment stack pointer");

  // Register, RAM and vector decode checks.
  a_wdog_read: assert property (i_rd && i_addr == 16'hFFFF |=> o_rdata == RESET_VEC_LO)
    else $error("watchdog location read wrong");
  a_wdog_clear: assert property (i_wr && i_addr == 16'hFFFF |=> s_ff.wdog_cnt == '0 && !o_wdog_timeout)
    else $error("watchdog not cleared by write");
  a_lvs_bits: assert property (i_rd && i_addr == 16'hFE0C |=> o_rdata[6:0] == 7'h00)
    else $error("low-voltage byte reserved bits set");
  a_brk_bits: assert property (i_rd && i_addr == 16'hFE0B |=> o_rdata[5:0] == 6'h00
                               && o_rdata[7] == o_break_enable)
    else $error("break byte layout wrong");
  a_brk_low_rw: assert property (i_wr && i_addr == 16'hFE0A ##1 !i_wr ##1 i_rd && i_addr == 16'hFE0A
                                 |=> o_rdata == $past(i_wdata, 3))
    else $error("break low byte did not read back");
  a_ram_hole: assert property (i_rd && i_addr == 16'h0440 |=> o_rdata == 8'h00)
    else $error("byte past RAM end answered");
  a_vec_adc: assert property (i_vec_fetch && !i_swi && i_int_req[14] && ~|i_int_req[13:0]
                              |=> o_vec_addr == 16'hFFDE && o_vec_valid)
    else $error("converter vector not selected");

  // Stack, vector, break and RAM hole checks that the bench scenarios all reach.
  a_sp_load: assert property (idle_go && !i_stack_irq && !i_stack_call && !i_stack_push
                              && !i_stack_pull && i_sp_load |=> o_sp == $past(i_sp_value))
    else $error("stack pointer load did not take");
  a_busy_step: assert property (o_stack_busy
                                |=> o_sp == $past(o_sp) - mvd_pkg::SP_STEP)
    else $error("frame byte did not move stack pointer");
  a_vec_reset: assert property (i_vec_fetch && !i_swi && ~|i_int_req
                                |=> o_vec_valid && o_vec_addr == mvd_pkg::VEC_RESET)
    else $error("idle fetch did not give reset vector");
  a_vec_swi: assert property (i_vec_fetch && i_swi
                              |=> o_vec_addr == mvd_pkg::VEC_SWI)
    else $error("software interrupt vector not selected");
  a_valid_pulse: assert property (!i_vec_fetch
                                  |=> !o_vec_valid)
    else $error("vector valid without fetch");
  a_brk_set: assert property (o_break_enable && i_break_match
                              |=> s_ff.brk_act)
    else $error("break hit did not set active flag");
  a_brk_clear: assert property (i_wr && i_addr == mvd_pkg::BRK_SC_ADDR && !i_wdata[mvd_pkg::BRK_ACT_BIT]
                                && !(o_break_enable && i_break_match) |=> !s_ff.brk_act)
    else $error("break active flag not cleared");
  a_ram_hole_low: assert property (i_rd && i_addr == mvd_pkg::RAM_FIRST - 16'h0001
                                   |=> o_rdata == mvd_pkg::BYTE_ZERO)
    else $error("byte below RAM start answered");

  c_irq_frame: cover property (idle_go && i_stack_irq ##6 !o_stack_busy);
  c_vec_fetch: cover property (i_vec_fetch ##1 o_vec_valid && o_vec_addr != 16'hFFFE);
  c_wdog_write: cover property (i_wr && i_addr == 16'hFFFF);
  c_irq_out: cover property ($rose(o_irq));
  c_call_frame: cover property (idle_go && i_stack_call ##3 !o_stack_busy);

endmodule // mvd_core

// [core/mvd_pkg.sv]
// Constants shared by the memory map and vector decode block.
// Assumes an 8-bit CPU core with a 16-bit address bus on one clock.
// What this block does
// - Decode 0040 through 043F as RAM.
// - Stack pointer is 16 bits wide.
// - Reset loads stack pointer with 00FF.
// - Page zero holds 192 RAM bytes.
// - Interrupt entry pushes five bytes, high index excluded.
// - Subroutine call pushes two-byte return address.
// - Push decrements, pull increments stack pointer.
// - Fixed vector table, priority rising with address.
// - Vector high byte even, low byte odd.
// - Converter complete vector sits at FFDE.
// - Reading FFFF returns reset vector low.
// - Any write to FFFF clears watchdog.
// - Low-voltage byte: bit 7 indicator only.
// - Break byte: enable bit 7, active bit 6.
// - Break address low byte, read/write, resets zero.
package mvd_pkg;
  localparam logic [15:0] RAM_FIRST     = 16'h0040;
  localparam logic [15:0] RAM_LAST      = 16'h043F;
  localparam logic [15:0] PAGE0_LAST    = 16'h00FF;
  localparam logic [15:0] SP_RESET      = 16'h00FF;
  localparam logic [15:0] SP_STEP       = 16'h0001;
  localparam int          RAM_BYTES     = 1024;
  localparam int          RAM_IDX_W     = 10;
  localparam int          PAGE0_BYTES   = 192;
  localparam logic [15:0] BRK_LO_ADDR   = 16'hFE0A;
  localparam logic [15:0] BRK_SC_ADDR   = 16'hFE0B;
  localparam logic [15:0] LVS_ADDR      = 16'hFE0C;
  localparam logic [15:0] IRQ_STAT_ADDR = 16'hFE0D;
  localparam logic [15:0] IRQ_MASK_ADDR = 16'hFE0E;
  localparam logic [15:0] PROTECT_ADDR  = 16'hFF7E;
  localparam logic [15:0] VEC_FIRST     = 16'hFFD4;
  localparam logic [15:0] VEC_ADC       = 16'hFFDE;
  localparam logic [15:0] VEC_SWI       = 16'hFFFC;
  localparam logic [15:0] VEC_RESET     = 16'hFFFE;
  localparam logic [15:0] WDOG_ADDR     = 16'hFFFF;
  localparam logic [15:0] VEC_STRIDE    = 16'h0002;
  localparam int          VEC_BYTES     = 43;
  localparam int          VEC_IDX_W     = 6;
  localparam int          NUM_IF        = 20;
  localparam int          ADC_IF_IDX    = 14;
  localparam logic [2:0]  IRQ_FRAME     = 3'h5;
  localparam logic [2:0]  CALL_FRAME    = 3'h2;
  localparam logic [2:0]  FRAME_STEP    = 3'h1;
  localparam int          BRK_EN_BIT    = 7;
  localparam int          BRK_ACT_BIT   = 6;
  localparam int          LV_IND_BIT    = 7;
  localparam int          NUM_EV        = 3;
  localparam int          EV_BREAK      = 0;
  localparam int          EV_LV         = 1;
  localparam int          EV_WDOG       = 2;
  localparam int          WDOG_W        = 20;
  localparam logic [7:0]  BYTE_ZERO     = 8'h00;
endpackage

// [verif/mvd_core_tb.sv]
// Self-checking bench for the memory map and vector decode block.
// Assumes the design of core/ and the interrupt source model of verif/.
module mvd_core_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_sys_clk = 1'b0, i_reset_n = 1'b0, wr = 1'b0, rd = 1'b0, software_interrupt = 1'b0, lowv = 1'b0, drop = 1'b0;
  // One bit per pulsed strobe, so a single task can drive any of them.
  logic [6:0]  stb = 7'h00;
  localparam int IRQ = 0, CALL = 1, PUSH = 2, PULL = 3, SPLD = 4, FETCH = 5, BMATCH = 6;
  logic [7:0]  xr = 8'h56, acc = 8'h78, ccr = 8'h9A;
  logic [15:0] addr = 16'h0000, pc = 16'h1234, spv = 16'h0400, sp, vaddr, vec;
  logic [7:0]  wdata = 8'h00, pdata = 8'h11, rdata, pulld, blow, prot, rd_val;
  logic [19:0] raise = 20'h00000, ireq;
  logic        busy, vvalid, ben, wto, o_irq;
  int          num_errors = 0, cmp_count = 0, n;
  typedef struct { logic [19:0] r; logic s; logic [15:0] a; logic [15:0] v; } row_s;
  row_s rows [6] = '{'{20'h00004, 1'b0, 16'hFFF6, 16'h1234}, '{20'h84000, 1'b0, 16'hFFDE, 16'hADC0},
                     '{20'h80000, 1'b0, 16'hFFD4, 16'h0000}, '{20'h00001, 1'b1, 16'hFFFC, 16'h0000},
                     '{20'h00005, 1'b0, 16'hFFFA, 16'h0000}, '{20'h00000, 1'b0, 16'hFFFE, 16'h00A5}};

  always #10 i_sys_clk = ~i_sys_clk;

  mvd_core #(.RESET_VEC_LO(8'hA5), .PROTECT_INIT(8'hFF), .WDOG_LIMIT(20'h00040)) dut (
    .i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
    .o_rdata(rdata), .i_stack_irq(stb[IRQ]), .i_stack_call(stb[CALL]), .i_stack_push(stb[PUSH]),
    .i_stack_pull(stb[PULL]), .i_sp_load(stb[SPLD]), .i_sp_value(spv), .i_push_data(pdata), .i_pc(pc),
    .i_x(xr), .i_acc(acc), .i_ccr(ccr), .o_sp(sp), .o_stack_busy(busy), .o_pull_data(pulld),
    .i_int_req(ireq), .i_swi(software_interrupt), .i_vec_fetch(stb[FETCH]), .o_vec_addr(vaddr), .o_vector(vec),
    .o_vec_valid(vvalid), .i_break_match(stb[BMATCH]),
    .o_break_enable(ben), .o_break_low(blow), .i_low_voltage(lowv), .o_protect(prot),
    .o_wdog_timeout(wto), .o_irq(o_irq));
  mvd_irq_src src (.i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n), .i_raise(raise), .i_drop_all(drop),
    .i_vec_valid(vvalid), .i_vec_addr(vaddr), .o_int_req(ireq));

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic bus_wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge i_sys_clk) begin wr <= 1'b1; addr <= a; wdata <= d; end
    @(posedge i_sys_clk) wr <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe, so it is taken right there.
  task automatic bus_rd(input logic [15:0] a);
    @(posedge i_sys_clk) begin rd <= 1'b1; addr <= a; end
    @(posedge i_sys_clk) rd <= 1'b0;
    #1 rd_val = rdata;
  endtask

  task automatic pulse(input int b, input int wait_n);
    @(posedge i_sys_clk) stb[b] <= 1'b1;
    @(posedge i_sys_clk) stb[b] <= 1'b0;
    repeat (wait_n) @(posedge i_sys_clk);
    #1;
  endtask

  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // Cut a hang short well beyond the few hundred cycles the tests take.
  initial begin
    #400000;
    num_errors++;
    summarize();
  end

  initial begin
    repeat (3) @(posedge i_sys_clk);
    i_reset_n <= 1'b1;
    #1 check(sp, 16'h00FF);
    bus_rd(16'hFE0A); check(rd_val, 16'h0000);
    bus_rd(16'hFE0B); check(rd_val, 16'h0000);
    bus_rd(16'hFE0C); check(rd_val, 16'h0000);
    bus_rd(16'hFF7E); check(rd_val, 16'h00FF);
    bus_rd(16'h2000); check(rd_val, 16'h0000);
    // Vector table rows; stored bytes put high at the even address.
    bus_wr(16'hFFF6, 8'h12); bus_wr(16'hFFF7, 8'h34); bus_wr(16'hFFDE, 8'hAD); bus_wr(16'hFFDF, 8'hC0);
    foreach (rows[i]) begin
      @(posedge i_sys_clk) raise <= rows[i].r;
      @(posedge i_sys_clk) begin raise <= 20'h00000; software_interrupt <= rows[i].s; end
      pulse(FETCH, 0);
      check(vvalid, 16'h0001);
      check(vaddr, rows[i].a);
      check(vec, rows[i].v);
      @(posedge i_sys_clk) begin drop <= 1'b1; software_interrupt <= 1'b0; end
      @(posedge i_sys_clk) drop <= 1'b0;
    end
    // RAM edges and page zero.
    bus_wr(16'h0040, 8'h3C); bus_wr(16'h043F, 8'hC3); bus_wr(16'h003F, 8'h77); bus_wr(16'h0440, 8'h77);
    bus_rd(16'h0040); check(rd_val, 16'h003C);
    bus_rd(16'h043F); check(rd_val, 16'h00C3);
    bus_rd(16'h0440); check(rd_val, 16'h0000);
    bus_rd(16'h003F); check(rd_val, 16'h0000);
    // Interrupt frame from the reset stack pointer, which stays in RAM here.
    pulse(IRQ, 0);
    check(busy, 16'h0001);
    repeat (5) @(posedge i_sys_clk);
    #1 check(busy, 16'h0000);
    check(sp, 16'h00FA);
    for (int k = 0; k < 5; k++) begin
      bus_rd(16'h00FF - 16'(k));
      check(rd_val, k == 0 ? 16'h0034 : k == 1 ? 16'h0012 : k == 2 ? 16'h0056 : k == 3 ? 16'h0078 : 16'h009A);
    end
    pulse(PULL, 0); check(sp, 16'h00FB);
    check(pulld, 16'h009A);
    pc <= 16'hABCD;
    pulse(CALL, 3); check(sp, 16'h00F9);
    bus_rd(16'h00FB); check(rd_val, 16'h00CD);
    bus_rd(16'h00FA); check(rd_val, 16'h00AB);
    pulse(PUSH, 0); check(sp, 16'h00F8);
    bus_rd(16'h00F9); check(rd_val, 16'h0011);
    pulse(SPLD, 0); check(sp, 16'h0400);
    // Register fields: read-only and reserved bits stay zero.
    bus_wr(16'hFE0A, 8'h5A); bus_rd(16'hFE0A); check(rd_val, 16'h005A);
    check(blow, 16'h005A);
    bus_wr(16'hFE0C, 8'hFF); bus_rd(16'hFE0C); check(rd_val, 16'h0000);
    bus_wr(16'hFE0B, 8'hFF); bus_rd(16'hFE0B); check(rd_val, 16'h0080);
    check(ben, 16'h0001);
    pulse(BMATCH, 0); bus_rd(16'hFE0B); check(rd_val, 16'h00C0);
    bus_wr(16'hFE0B, 8'h80); bus_rd(16'hFE0B); check(rd_val, 16'h0080);
    @(posedge i_sys_clk) lowv <= 1'b1;
    repeat (6) @(posedge i_sys_clk);
    bus_rd(16'hFE0C); check(rd_val, 16'h0080);
    bus_rd(16'hFFFF); check(rd_val, 16'h00A5);
    // Watchdog: service, then time the next expiry against the small limit.
    // The counter restarts at the write and expires after limit plus one edges.
    bus_wr(16'hFFFF, 8'h00);
    #1 n = 0;
    while (wto !== 1'b1 && n < 200) begin
      @(posedge i_sys_clk);
      #1 n++;
    end
    check(16'(n), 16'h0041);
    bus_wr(16'hFE0E, 8'h04);
    #1 check(o_irq, 16'h0001);
    bus_wr(16'hFE0D, 8'h07);
    @(posedge i_sys_clk);
    #1 check(o_irq, 16'h0000);
    // Reset in mid-run reloads the protect image and clears the break bytes.
    bus_wr(16'hFF7E, 8'h3C);
    #1 check(prot, 16'h003C);
    @(posedge i_sys_clk) i_reset_n <= 1'b0;
    @(posedge i_sys_clk) i_reset_n <= 1'b1;
    #1 check(prot, 16'h00FF);
    check(sp, 16'h00FF);
    check(blow, 16'h0000);
    bus_rd(16'hFE0B); check(rd_val, 16'h0000);
    summarize();
  end
endmodule // mvd_core_tb

// [verif/mvd_irq_src.sv]
// Behavioural model of the peripheral interrupt sources beside the decode block.
// Assumes one system clock; a source holds its request until its vector is fetched.
module mvd_irq_src (
  input  wire logic        i_sys_clk,   // System clock.
  input  wire logic        i_reset_n,   // Asynchronous reset, active low.
  input  wire logic [19:0] i_raise,     // One-cycle pulse per source to raise.
  input  wire logic        i_drop_all,  // Withdraw every request.
  input  wire logic        i_vec_valid, // Vector fetch answered.
  input  wire logic [15:0] i_vec_addr,  // Address of the served vector.
  output logic      [19:0] o_int_req    // Held request levels.
);
  timeunit 1ns;
  timeprecision 1ps;

  // A request stays up until served, so a slow core still sees it.
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_int_req <= 20'h00000;
    end else if (i_drop_all) begin
      o_int_req <= 20'h00000;
    end else begin
      o_int_req <= o_int_req | i_raise;
      for (int i = 0; i < 20; i++) begin
        if (i_vec_valid && i_vec_addr == 16'hFFFC - 16'(2 * (i + 1))) begin
          o_int_req[i] <= 1'b0;
        end
      end
    end
  end
endmodule // mvd_irq_src
